/* File: logic/serial_port_defines.vh */
// register offsets, field codes and constants of the async serial port
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH
`define ADDR_TX_LO        3'h0
`define ADDR_TX_HI        3'h1
`define ADDR_RX_LO        3'h2
`define ADDR_RX_HI        3'h3
`define ADDR_RELOAD       3'h4
`define ADDR_MODE         3'h5
`define ADDR_CTRL0        3'h6
`define ADDR_CTRL1        3'h7
`define MODE_SEVEN        3'h4
`define MODE_EIGHT        3'h5
`define MODE_NINE         3'h6
`define MODE_RESET        8'h00
`define CTRL0_RESET       8'h08
`define CTRL1_RESET       8'h02
`define RELOAD_RESET      8'h00
`define SAMPLES_PER_BIT   4'hf
`define SAMPLE_MID        4'h7
`define PRE_UNDIVIDED     2'h0
`define PRE_DIV8          2'h1
`define PRE_DIV32         2'h2
`define PRE_SUB           2'h3
`endif

/* File: logic/rx_filter.v */
// three-stage majority-free match filter for the serial input
`timescale 1ns/1ps
`default_nettype none
module rx_filter (
  input  wire sys_clk,
  input  wire rst,
  input  wire tick,
  input  wire enable,
  input  wire raw_in,
  output wire filtered
);
  reg [2:0] taps;
  reg       held;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      taps <= 3'h7;
      held <= 1'b1;
    end else if (tick) begin
      taps <= {taps[1:0], raw_in};
      // a level must stand for three sample ticks before it passes
      if (taps == 3'h7)
        held <= 1'b1;
      else if (taps == 3'h0)
        held <= 1'b0;
    end
  end
  assign filtered = enable ? held : raw_in;
endmodule
`default_nettype wire

/* File: logic/async_serial_port.v */
// asynchronous serial channel: registers, bit-rate divider, tx and rx
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defines.vh"
module async_serial_port (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire [2:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  input  wire       subclock_source,
  input  wire       pin_clock_in,
  input  wire       rxd,
  output wire       txd_out,
  output wire       txd_oe,
  output wire       tx_irq,
  output wire       rx_irq
);
  localparam TX_IDLE = 2'h0;
  localparam TX_RUN  = 2'h1;
  localparam RX_IDLE = 2'h0;
  localparam RX_RUN  = 2'h1;

  reg [7:0] bit_rate_reload;
  reg [7:0] serial_mode_control;
  reg [7:0] serial_control_zero;
  reg [7:0] serial_control_one;
  reg [8:0] transmit_buffer;
  reg [8:0] rx_data;
  reg       overflow_fault;
  reg       frame_fault;
  reg       parity_fault;
  reg       rx_full_flag;
  reg       tx_hold_empty;

  wire [2:0] serial_mode_sel  = serial_mode_control[2:0];
  wire       clock_source_ext = serial_mode_control[3];
  wire       stop_count       = serial_mode_control[4];
  wire       parity_sense     = serial_mode_control[5];
  wire       parity_on        = serial_mode_control[6];
  wire [1:0] prescale_sel     = serial_control_zero[1:0];
  wire       rx_noise_filter_on = serial_control_zero[4];
  wire       txd_open_drain   = serial_control_zero[5];
  wire       bit_order        = serial_control_zero[7];
  wire       tx_on            = serial_control_one[0];
  wire       rx_on            = serial_control_one[2];
  wire       tx_irq_source    = serial_control_one[4];

  // character length from mode; an unlisted mode leaves the channel idle
  function [3:0] char_len;
    input [2:0] m;
    begin
      case (m)
        `MODE_SEVEN: char_len = 4'd7;
        `MODE_EIGHT: char_len = 4'd8;
        `MODE_NINE:  char_len = 4'd9;
        default:     char_len = 4'd0;
      endcase
    end
  endfunction
  wire [3:0] nbits = char_len(serial_mode_sel);
  wire uart_on = (nbits != 4'd0);
  wire msb_first = bit_order & (nbits == 4'd8);

  // count source: prescaler and external pin edge detect
  reg [4:0] prescale;
  reg [1:0] pin_hist;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prescale <= 5'h00;
      pin_hist <= 2'h0;
    end else begin
      prescale <= prescale + 5'h01;
      pin_hist <= {pin_hist[0], pin_clock_in};
    end
  end
  wire sub_rise = 1'b0;
  reg  [1:0] sub_hist;
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      sub_hist <= 2'h0;
    else
      sub_hist <= {sub_hist[0], subclock_source};
  end
  reg src_tick;
  always @* begin
    case (prescale_sel)
      `PRE_UNDIVIDED: src_tick = 1'b1;
      `PRE_DIV8:      src_tick = (prescale[2:0] == 3'h7);
      `PRE_DIV32:     src_tick = (prescale == 5'h1f);
      `PRE_SUB:       src_tick = sub_hist[0] & ~sub_hist[1];
      default:        src_tick = sub_rise;
    endcase
    if (clock_source_ext)
      src_tick = pin_hist[0] & ~pin_hist[1];
  end

  // reload divider produces the 16x sample tick
  reg [7:0] brg_count;
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      brg_count <= 8'h00;
    else if (src_tick) begin
      if (brg_count == 8'h00)
        brg_count <= bit_rate_reload;
      else
        brg_count <= brg_count - 8'h01;
    end
  end
  wire tick16 = src_tick & (brg_count == 8'h00);

  // transmitter
  reg [1:0]  tx_state;
  reg [11:0] tx_shift;
  reg [3:0]  tx_left;
  reg [3:0]  tx_phase;
  reg        txd_level;
  reg        shift_empty;
  reg [8:0]  tx_load;
  integer    i;
  always @* begin
    tx_load = 9'h000;
    for (i = 0; i < 9; i = i + 1)
      if (i < nbits)
        tx_load[i] = msb_first ? transmit_buffer[7 - i] : transmit_buffer[i];
  end
  wire tx_par = ^tx_load ^ ~parity_sense;
  wire [3:0] tx_total = 4'd1 + nbits + {3'h0, parity_on} + 4'd1 +
                        {3'h0, stop_count};
  // stop positions and everything past the frame stay high
  reg [11:0] tx_frame;
  integer    f;
  always @* begin
    tx_frame = 12'hffe;
    for (f = 0; f < 9; f = f + 1)
      if (f < nbits)
        tx_frame[f + 1] = tx_load[f];
    if (parity_on)
      tx_frame[nbits + 4'd1] = tx_par;
  end
  // combinational so a buffer write in the load cycle is not lost
  wire tx_go = (tx_state == TX_IDLE) && tx_on && uart_on &&
               !tx_hold_empty && tick16;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_state    <= TX_IDLE;
      tx_shift    <= 12'hfff;
      tx_left     <= 4'h0;
      tx_phase    <= 4'h0;
      txd_level   <= 1'b1;
      shift_empty <= 1'b1;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_go) begin
            tx_shift    <= tx_frame;
            tx_left     <= tx_total;
            tx_phase    <= 4'h0;
            shift_empty <= 1'b0;
            tx_state    <= TX_RUN;
          end
        end
        TX_RUN: begin
          if (tick16) begin
            if (tx_phase == 4'h0)
              txd_level <= tx_shift[0];
            tx_phase <= tx_phase + 4'h1;
            if (tx_phase == `SAMPLES_PER_BIT) begin
              tx_shift <= {1'b1, tx_shift[11:1]};
              tx_left  <= tx_left - 4'h1;
              if (tx_left == 4'h1) begin
                shift_empty <= 1'b1;
                tx_state    <= TX_IDLE;
              end
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end
  assign txd_out = txd_open_drain ? 1'b0 : txd_level;
  assign txd_oe  = txd_open_drain ? ~txd_level : 1'b1;
  assign tx_irq  = tx_irq_source ? shift_empty : tx_hold_empty;

  // receiver
  wire rx_line;
  rx_filter filt (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .tick     (tick16),
    .enable   (rx_noise_filter_on),
    .raw_in   (rxd),
    .filtered (rx_line)
  );
  reg [1:0]  rx_state;
  reg [3:0]  rx_phase;
  reg [3:0]  rx_idx;
  reg [11:0] rx_shift;
  reg        rx_stop_bad;
  reg        rx_done;
  reg [3:0]  rx_total;
  reg        rx_prev;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_prev     <= 1'b1;
      rx_state    <= RX_IDLE;
      rx_phase    <= 4'h0;
      rx_idx      <= 4'h0;
      rx_shift    <= 12'h000;
      rx_stop_bad <= 1'b0;
      rx_done     <= 1'b0;
      rx_total    <= 4'h0;
    end else begin
      rx_done <= 1'b0;
      // a low line after a broken stop bit must not count as a start
      if (tick16)
        rx_prev <= rx_line;
      case (rx_state)
        RX_IDLE: begin
          if (rx_on && uart_on && tick16 && rx_prev && !rx_line) begin
            rx_state    <= RX_RUN;
            rx_phase    <= 4'h1;
            rx_idx      <= 4'h0;
            rx_stop_bad <= 1'b0;
            rx_total    <= tx_total;
          end
        end
        RX_RUN: begin
          if (tick16) begin
            rx_phase <= rx_phase + 4'h1;
            if (rx_phase == `SAMPLE_MID) begin
              if (rx_idx == 4'h0 && rx_line)
                rx_state <= RX_IDLE;
              rx_shift[rx_idx] <= rx_line;
              if (rx_idx > nbits + {3'h0, parity_on} && !rx_line)
                rx_stop_bad <= 1'b1;
              rx_idx <= rx_idx + 4'h1;
              if (rx_idx == rx_total - 4'h1) begin
                rx_done  <= 1'b1;
                rx_state <= RX_IDLE;
              end
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end
  reg [8:0] rx_word;
  integer   k;
  always @* begin
    rx_word = 9'h000;
    for (k = 0; k < 9; k = k + 1)
      if (k < nbits)
        rx_word[k] = msb_first ? rx_shift[8 - k] : rx_shift[k + 1];
  end
  wire rx_par_bad = parity_on &
    ((^rx_word) ^ rx_shift[nbits + 4'd1] ^ ~parity_sense);
  // overrun is judged at the bit before the last stop
  wire rx_near_end = (rx_state == RX_RUN) && tick16 &&
                     (rx_phase == `SAMPLE_MID) && (rx_idx == rx_total - 4'h2);
  wire rx_hi_read = rd && (addr == `ADDR_RX_HI);

  // register write and buffer/flag maintenance
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_rate_reload     <= `RELOAD_RESET;
      serial_mode_control <= `MODE_RESET;
      serial_control_zero <= `CTRL0_RESET;
      serial_control_one  <= `CTRL1_RESET;
      transmit_buffer     <= 9'h000;
      tx_hold_empty       <= 1'b1;
      rx_data             <= 9'h000;
      rx_full_flag        <= 1'b0;
      overflow_fault      <= 1'b0;
      frame_fault         <= 1'b0;
      parity_fault        <= 1'b0;
    end else begin
      if (tx_go)
        tx_hold_empty <= 1'b1;
      if (wr) begin
        case (addr)
          `ADDR_TX_LO: begin
            transmit_buffer[7:0] <= wdata;
            tx_hold_empty        <= 1'b0;
          end
          `ADDR_TX_HI:  transmit_buffer[8] <= wdata[0];
          `ADDR_RELOAD: bit_rate_reload <= wdata;
          `ADDR_MODE:   serial_mode_control <= wdata;
          // shift_empty is read-only
          `ADDR_CTRL0:  serial_control_zero <= {wdata[7:4], 1'b0, wdata[2:0]};
          // rx_full and tx_hold_empty bits are read-only
          `ADDR_CTRL1:  serial_control_one <= {2'h0, wdata[5:4], 1'b0,
                                               wdata[2], 1'b0, wdata[0]};
          default: ;
        endcase
      end
      if (rx_hi_read) begin
        frame_fault    <= 1'b0;
        parity_fault   <= 1'b0;
        overflow_fault <= 1'b0;
        rx_full_flag   <= 1'b0;
      end
      // a capture in the same cycle as the clearing read wins
      if (rx_near_end && rx_full_flag && !rx_hi_read)
        overflow_fault <= 1'b1;
      if (rx_done) begin
        if (!(rx_full_flag && !rx_hi_read))
          rx_data <= rx_word;
        frame_fault  <= rx_stop_bad;
        parity_fault <= rx_par_bad;
        rx_full_flag <= 1'b1;
      end
    end
  end
  assign rx_irq = rx_full_flag;
  wire any_fault = overflow_fault | frame_fault | parity_fault;

  // read data one cycle after the strobe
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      rdata <= 8'h00;
    else if (rd) begin
      case (addr)
        `ADDR_RX_LO:  rdata <= rx_data[7:0];
        `ADDR_RX_HI:  rdata <= {any_fault, parity_fault, frame_fault,
                                overflow_fault, 3'h0, rx_data[8]};
        `ADDR_RELOAD: rdata <= bit_rate_reload;
        `ADDR_MODE:   rdata <= serial_mode_control;
        `ADDR_CTRL0:  rdata <= {serial_control_zero[7:4], shift_empty,
                                serial_control_zero[2:0]};
        `ADDR_CTRL1:  rdata <= {serial_control_one[7:4], rx_full_flag,
                                serial_control_one[2], tx_hold_empty,
                                serial_control_one[0]};
        default:      rdata <= 8'h00;
      endcase
    end else
      rdata <= 8'h00;
  end
endmodule
`default_nettype wire

/* File: sim/async_serial_port_sva.sv */
// checker for the serial port register reads and serial pin
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_sva (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       subclock_source,
  input wire logic       pin_clock_in,
  input wire logic       rxd,
  input wire logic       txd_out,
  input wire logic       txd_oe,
  input wire logic       tx_irq,
  input wire logic       rx_irq
);
  logic [7:0]  rl;
  logic [1:0]  pre;
  logic        ext;
  logic        od;
  logic        src;
  logic [15:0] low_run;
  wire         line    = txd_oe ? txd_out : 1'b1;
  wire  [15:0] bit_len = {4'h0, rl, 4'h0} + 16'h0010;
  // shadows of the config fields that the pin checks depend on
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rl      <= 8'h00;
      pre     <= 2'h0;
      ext     <= 1'b0;
      od      <= 1'b0;
      src     <= 1'b0;
      low_run <= 16'h0000;
    end else begin
      low_run <= line ? 16'h0000 : low_run + 16'h0001;
      if (wr && addr == 3'h4)
        rl <= wdata;
      if (wr && addr == 3'h5)
        ext <= wdata[3];
      if (wr && addr == 3'h6)
        {od, pre} <= {wdata[5], wdata[1:0]};
      if (wr && addr == 3'h7)
        src <= wdata[4];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence hi_read;
    rd && addr == 3'h3;
  endsequence
  sequence ctrl1_read;
    rd && addr == 3'h7;
  endsequence
  chk_rdata_quiet:
    assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero without a read");
  chk_rx_mirror:
    assert property (ctrl1_read |=> rdata[3] == $past(rx_irq))
    else $error("receive full bit differs from rx_irq");
  chk_tx_mirror:
    assert property (ctrl1_read |=> rdata[4] || rdata[1] == $past(tx_irq))
    else $error("tx_irq differs from buffer empty flag");
  chk_fault_sum:
    assert property (hi_read |=> rdata[7] == |rdata[6:4])
    else $error("fault summary bit wrong");
  chk_rx_clear:
    assert property ($fell(rx_irq) |-> $past(rd && addr == 3'h3))
    else $error("rx_irq dropped without a high byte read");
  chk_pin_drive:
    assert property (od == $past(od) |-> (od ? !txd_out : txd_oe))
    else $error("serial output drive type wrong");
  chk_bit_len:
    assert property ($rose(line) && pre == 2'h0 && !ext
                     |-> low_run % bit_len == 16'h0000)
    else $error("low run not a whole number of bit periods");
  chk_idle_empty:
    assert property (src && $past(src) && tx_irq |-> line)
    else $error("shift empty while line not idle");
endmodule
bind async_serial_port async_serial_port_sva u_sva (
  .sys_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .subclock_source,
  .pin_clock_in, .rxd, .txd_out, .txd_oe, .tx_irq, .rx_irq);
`default_nettype wire

/* File: sim/serial_partner.sv */
// remote serial device: sends frames on rxd, captures frames off the line
`timescale 1ns/1ps
`default_nettype none
module serial_partner (
  input  wire logic sys_clk,
  input  wire logic line,
  output var  logic rxd
);
  initial rxd = 1'b1;
  // bits go out lsb first; the line returns to its idle high after
  task automatic send(input logic [12:0] v, input int nb, input int bl);
    for (int i = 0; i < nb * bl; i++) begin
      @(posedge sys_clk);
      rxd <= v[i / bl];
    end
    @(posedge sys_clk);
    rxd <= 1'b1;
  endtask
  // samples at bit centres; a missing start bit leaves r all ones
  task automatic get(output logic [12:0] r, input int nb, input int bl);
    int t;
    r = 13'h1fff;
    t = 0;
    while (line && t < 8 * bl) begin
      @(posedge sys_clk);
      t++;
    end
    repeat (bl / 2) @(posedge sys_clk);
    for (int i = 0; i < nb; i++) begin
      r[i] = line;
      repeat (bl) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: sim/async_serial_port_setup_test.sv */
// self-checking bench for the asynchronous serial port
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defines.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  fail_count++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module async_serial_port_setup_test;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [2:0]  addr    = 3'h0;
  logic [7:0]  wdata   = 8'h00;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [7:0]  rdata;
  logic        txd_out, txd_oe, tx_irq, rx_irq, rxd;
  logic [12:0] got;
  logic [15:0] seed    = 16'h0037;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  wire         line = txd_oe ? txd_out : 1'b1;
  async_serial_port u_async_serial_port (.sys_clk, .rst, .addr, .wdata, .wr,
    .rd, .rdata, .subclock_source(1'b0), .pin_clock_in(1'b0), .rxd,
    .txd_out, .txd_oe, .tx_irq, .rx_irq);
  serial_partner u_serial_partner (.sys_clk, .line, .rxd);
  always #5 sys_clk = ~sys_clk;
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // the whole run needs about 6000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // line bits lsb first: start, data, parity, then ones
  function automatic logic [12:0] frame(input logic [8:0] d, input int n,
                                        input logic po, pe, ms);
    logic [12:0] v;
    logic [8:0]  x;
    x = d & (9'h1ff >> (9 - n));
    v = 13'h1ffe;
    for (int i = 0; i < n; i++)
      v[i + 1] = ms ? x[n - 1 - i] : x[i];
    if (po)
      v[n + 1] = pe ? ^x : ~^x;
    return v;
  endfunction
  initial begin
    logic [7:0]  r, h;
    logic [8:0]  d;
    logic [12:0] v;
    int          n, bl;
    logic        po, pe, two, ms, pre;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rreg(3'h4, r);
    `CHK("reload", `RELOAD_RESET, r)
    rreg(3'h5, r);
    `CHK("mode", `MODE_RESET, r)
    rreg(3'h6, r);
    `CHK("ctrl0", `CTRL0_RESET, r)
    wreg(3'h7, 8'h00);
    rreg(3'h7, r);
    `CHK("ctrl1", `CTRL1_RESET, r)
    for (int i = 0; i < 6; i++) begin
      seed = step(seed);
      n = 7 + i % 3;
      {po, pe, two} = seed[11:9];
      ms = n == 8 && seed[12];
      pre = i == 5;
      bl = pre ? 128 : 32;
      d = i == 0 ? 9'h1ff : seed[8:0];
      wreg(3'h5, {1'b0, po, pe, two, 1'b0, 3'(n - 3)});
      wreg(3'h6, {ms, 1'b0, seed[13], 4'h0, pre});
      wreg(3'h4, {7'h00, ~pre});
      wreg(3'h7, {3'h0, seed[15], 4'h5});
      wreg(3'h1, {7'h00, d[8]});
      wreg(3'h0, d[7:0]);
      u_serial_partner.get(got, n + 2 + po + two, bl);
      `CHK("tx frame", frame(d, n, po, pe, ms), got)
      repeat (bl) @(posedge sys_clk);
      rreg(3'h6, r);
      `CHK("shift empty", 1'b1, r[3])
      $display("tx test %0d done", i);
    end
    wreg(3'h5, 8'h45);
    wreg(3'h6, 8'h10);
    wreg(3'h4, 8'h01);
    for (int j = 0; j < 4; j++) begin
      seed = step(seed);
      d = {1'b0, seed[7:0]};
      v = frame(d, 8, 1'b1, 1'b0, 1'b0);
      if (j == 1)
        v[10] = 1'b0;
      if (j == 2)
        v[9] = ~v[9];
      u_serial_partner.send(v, 11, 32);
      if (j == 3)
        u_serial_partner.send(v, 11, 32);
      for (int t = 0; t < 64 && !rx_irq; t++)
        @(posedge sys_clk);
      `CHK("rx done", 1'b1, rx_irq)
      rreg(3'h2, r);
      rreg(3'h3, h);
      if (j != 3)
        `CHK("rx data", d[7:0], r)
      `CHK("rx faults", {j != 0, j == 2, j == 1, j == 3}, h[7:4])
      `CHK("rx cleared", 1'b0, rx_irq)
      $display("rx test %0d done", j);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
